// ==== hw/sfrp_pkg.sv ====
// constants and types for the serial flash read path
package sfrp_pkg;
    // read opcodes
    localparam logic [7:0] OP_NORMAL_READ = 8'h03;
    localparam logic [7:0] OP_FAST_READ = 8'h0B;
    localparam logic [7:0] OP_DUAL_IO_READ = 8'hBB;
    localparam logic [7:0] OP_QUAD_IO_READ = 8'hEB;
    localparam logic [7:0] OP_UNIQUE_ID_READ = 8'h4B;
    localparam logic [7:0] OP_PARAM_TABLE_READ = 8'h5A;
    localparam logic [7:0] OP_INFO_ROW_READ = 8'h68;

    // mode nibble that keeps continuous read
    localparam logic [3:0] MODE_CONT_NIBBLE = 4'hA;

    // clock counts per phase
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] OPCODE_CLKS_SINGLE = 5'h08;
    localparam logic [CNT_W-1:0] OPCODE_CLKS_QUAD = 5'h02;
    localparam logic [CNT_W-1:0] ADDR_CLKS_SINGLE = 5'h18;
    localparam logic [CNT_W-1:0] ADDR_CLKS_DUAL = 5'h0C;
    localparam logic [CNT_W-1:0] ADDR_CLKS_QUAD = 5'h06;
    localparam logic [CNT_W-1:0] DUMMY_CLKS_NONE = 5'h00;
    localparam logic [CNT_W-1:0] DUMMY_CLKS_FAST = 5'h08;
    localparam logic [CNT_W-1:0] MODE_NIBBLE_CLKS = 5'h02;

    // index of the last data chunk in a byte
    localparam logic [2:0] CHUNKS_SINGLE = 3'h7;
    localparam logic [2:0] CHUNKS_DUAL = 3'h3;
    localparam logic [2:0] CHUNKS_QUAD = 3'h1;

    // output enables, active low, io3..io0
    localparam logic [3:0] OE_N_IDLE = 4'hF;
    localparam logic [3:0] OE_N_SINGLE = 4'hD;
    localparam logic [3:0] OE_N_DUAL = 4'hC;
    localparam logic [3:0] OE_N_QUAD = 4'h0;

    // configuration vector layout
    localparam int CFG_WIP = 0;
    localparam int CFG_QE = 1;
    localparam int CFG_QPI = 2;
    localparam int CFG_DTR = 3;
    localparam int CFG_DD_LSB = 4;
    localparam int CFG_DQ_LSB = 8;
    localparam int CFG_W = 12;
    localparam logic [3:0] DUMMY_DUAL_DEFAULT = 4'h4;
    localparam logic [3:0] DUMMY_QUAD_DEFAULT = 4'h6;
    localparam logic [CFG_W-1:0] CFG_RESET = {DUMMY_QUAD_DEFAULT, DUMMY_DUAL_DEFAULT, 4'h0};

    typedef enum logic [2:0] {
        SFRP_ST_CMD = 3'b000,
        SFRP_ST_ADDR = 3'b001,
        SFRP_ST_DUMMY = 3'b010,
        SFRP_ST_DATA = 3'b011,
        SFRP_ST_IGNORE = 3'b100
    } sfrp_state_type;

    typedef enum logic [1:0] {
        SFRP_KIND_NORMAL = 2'b00,
        SFRP_KIND_FAST = 2'b01,
        SFRP_KIND_DUAL = 2'b10,
        SFRP_KIND_QUAD = 2'b11
    } sfrp_kind_type;
endpackage

// ==== hw/sfrp_read_path.sv ====
// device-side read command engine of a serial flash
`timescale 1ns/100ps
module sfrp_read_path #(
    parameter int ADDR_BITS = 23
) (
    // system clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // configuration
    input wire logic work_in_progress_flag,
    input wire logic quad_enable_bit,
    input wire logic quad_command_mode,
    input wire logic dtr_mode,
    input wire logic [3:0] dual_dummy_cycles,
    input wire logic [3:0] quad_dummy_cycles,
    // status
    output logic continuous_read_mode,
    output logic read_rejected,
    // memory array port
    output logic [ADDR_BITS-1:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    // serial link
    input wire logic sck,
    input wire logic cs_n,
    input wire logic hold_n,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe_n
);

    // system domain
    logic sys_rst;
    logic [sfrp_pkg::CFG_W-1:0] cfg_sys;
    logic [sfrp_pkg::CFG_W-1:0] next_cfg;
    logic cont_meta;
    logic rej_meta;
    logic rej_sync;
    logic rej_prev;

    // link domain
    logic [sfrp_pkg::CFG_W-1:0] cfg_meta;
    logic [sfrp_pkg::CFG_W-1:0] cfg_link;
    sfrp_pkg::sfrp_state_type state;
    sfrp_pkg::sfrp_state_type next_state;
    sfrp_pkg::sfrp_kind_type kind;
    sfrp_pkg::sfrp_kind_type next_kind;
    sfrp_pkg::sfrp_kind_type eff_kind;
    sfrp_pkg::sfrp_kind_type dec_kind;
    logic [sfrp_pkg::CNT_W-1:0] cnt;
    logic [sfrp_pkg::CNT_W-1:0] next_cnt;
    logic [2:0] bit_pos;
    logic [2:0] next_pos;
    logic [7:0] op_sr;
    logic [7:0] next_op;
    logic [23:0] addr_sr;
    logic [23:0] next_addr_sr;
    logic [1:0] mode_hi;
    logic cont_mode;
    logic rej_tgl;

    assign next_cfg = {quad_dummy_cycles, dual_dummy_cycles, dtr_mode, quad_command_mode,
                       quad_enable_bit, work_in_progress_flag};

    always_ff @(posedge sys_clk) begin
        sys_rst <= !rstn;
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cfg_sys <= sfrp_pkg::CFG_RESET;
        end else begin
            cfg_sys <= next_cfg;
        end
    end

    // status back into the system domain
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cont_meta <= 1'b0;
            continuous_read_mode <= 1'b0;
            rej_meta <= 1'b0;
            rej_sync <= 1'b0;
            rej_prev <= 1'b0;
            read_rejected <= 1'b0;
        end else begin
            cont_meta <= cont_mode;
            continuous_read_mode <= cont_meta;
            rej_meta <= rej_tgl;
            rej_sync <= rej_meta;
            rej_prev <= rej_sync;
            read_rejected <= rej_sync ^ rej_prev;
        end
    end

    // configuration into the link domain
    always_ff @(posedge sck or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_meta <= sfrp_pkg::CFG_RESET;
            cfg_link <= sfrp_pkg::CFG_RESET;
        end else begin
            cfg_meta <= cfg_sys;
            cfg_link <= cfg_meta;
        end
    end

    // decoded link settings
    wire wip_l = cfg_link[sfrp_pkg::CFG_WIP];
    wire qe_l = cfg_link[sfrp_pkg::CFG_QE];
    wire qpi_l = cfg_link[sfrp_pkg::CFG_QPI];
    wire dtr_l = cfg_link[sfrp_pkg::CFG_DTR];
    wire [3:0] dd_l = cfg_link[sfrp_pkg::CFG_DD_LSB +: 4];
    wire [3:0] dq_l = cfg_link[sfrp_pkg::CFG_DQ_LSB +: 4];

    // hold pause gating
    wire hold_active = !hold_n && !qe_l && !dtr_l;
    wire run = !hold_active;

    // opcode skipped in continuous read
    wire skip_op = (state == sfrp_pkg::SFRP_ST_CMD) && cont_mode && !qpi_l;
    assign eff_kind = skip_op ? sfrp_pkg::SFRP_KIND_DUAL : kind;
    wire in_addr = (state == sfrp_pkg::SFRP_ST_ADDR) || skip_op;

    // opcode shifting
    assign next_op = qpi_l ? {op_sr[3:0], io_in} : {op_sr[6:0], io_in[0]};
    wire [sfrp_pkg::CNT_W-1:0] op_clks = qpi_l ? sfrp_pkg::OPCODE_CLKS_QUAD
                                               : sfrp_pkg::OPCODE_CLKS_SINGLE;
    wire op_last = (state == sfrp_pkg::SFRP_ST_CMD) && !skip_op && (cnt == op_clks - 5'h01);

    // opcode decode
    wire q_hit = (next_op == sfrp_pkg::OP_FAST_READ) || (next_op == sfrp_pkg::OP_QUAD_IO_READ)
               || (next_op == sfrp_pkg::OP_UNIQUE_ID_READ)
               || (next_op == sfrp_pkg::OP_PARAM_TABLE_READ)
               || (next_op == sfrp_pkg::OP_INFO_ROW_READ);
    wire s_norm = next_op == sfrp_pkg::OP_NORMAL_READ;
    wire s_fast = next_op == sfrp_pkg::OP_FAST_READ;
    wire s_dual = next_op == sfrp_pkg::OP_DUAL_IO_READ;
    wire dec_valid = qpi_l ? q_hit : (s_norm || s_fast || s_dual);
    assign dec_kind = qpi_l ? sfrp_pkg::SFRP_KIND_QUAD
                    : s_fast ? sfrp_pkg::SFRP_KIND_FAST
                    : s_dual ? sfrp_pkg::SFRP_KIND_DUAL
                    : sfrp_pkg::SFRP_KIND_NORMAL;
    wire reject = (op_last && dec_valid && wip_l) || (skip_op && wip_l);

    // address shifting by lane count
    assign next_addr_sr = (eff_kind == sfrp_pkg::SFRP_KIND_QUAD) ? {addr_sr[19:0], io_in}
                        : (eff_kind == sfrp_pkg::SFRP_KIND_DUAL) ? {addr_sr[21:0], io_in[1:0]}
                        : {addr_sr[22:0], io_in[0]};
    wire [sfrp_pkg::CNT_W-1:0] addr_clks =
        (eff_kind == sfrp_pkg::SFRP_KIND_QUAD) ? sfrp_pkg::ADDR_CLKS_QUAD
        : (eff_kind == sfrp_pkg::SFRP_KIND_DUAL) ? sfrp_pkg::ADDR_CLKS_DUAL
        : sfrp_pkg::ADDR_CLKS_SINGLE;
    wire addr_last = in_addr && (cnt == addr_clks - 5'h01);

    // dummy length from stored read parameters
    wire [sfrp_pkg::CNT_W-1:0] dummy_clks =
        (kind == sfrp_pkg::SFRP_KIND_QUAD) ? {1'b0, dq_l}
        : (kind == sfrp_pkg::SFRP_KIND_DUAL) ? {1'b0, dd_l}
        : (kind == sfrp_pkg::SFRP_KIND_FAST) ? sfrp_pkg::DUMMY_CLKS_FAST
        : sfrp_pkg::DUMMY_CLKS_NONE;
    wire dummy_last = (state == sfrp_pkg::SFRP_ST_DUMMY) && (cnt == dummy_clks - 5'h01);

    // mode nibble in the first dummy clocks
    wire mode_take = (state == sfrp_pkg::SFRP_ST_DUMMY) && (kind == sfrp_pkg::SFRP_KIND_DUAL);
    wire mode_done = mode_take && (cnt == sfrp_pkg::MODE_NIBBLE_CLKS - 5'h01);
    wire mode_keep = {mode_hi, io_in[1:0]} == sfrp_pkg::MODE_CONT_NIBBLE;

    // data position
    wire [2:0] chunks = (kind == sfrp_pkg::SFRP_KIND_QUAD) ? sfrp_pkg::CHUNKS_QUAD
                      : (kind == sfrp_pkg::SFRP_KIND_DUAL) ? sfrp_pkg::CHUNKS_DUAL
                      : sfrp_pkg::CHUNKS_SINGLE;
    wire byte_last = (state == sfrp_pkg::SFRP_ST_DATA) && (bit_pos == chunks);

    always_comb begin
        next_state = state;
        next_kind = kind;
        next_cnt = cnt + 5'h01;
        next_pos = bit_pos;
        case (state)
            sfrp_pkg::SFRP_ST_CMD: begin
                if (skip_op) begin
                    next_kind = sfrp_pkg::SFRP_KIND_DUAL;
                    next_state = wip_l ? sfrp_pkg::SFRP_ST_IGNORE : sfrp_pkg::SFRP_ST_ADDR;
                end else if (op_last) begin
                    next_cnt = 5'h00;
                    next_kind = dec_kind;
                    if (dec_valid && !wip_l) begin
                        next_state = sfrp_pkg::SFRP_ST_ADDR;
                    end else begin
                        next_state = sfrp_pkg::SFRP_ST_IGNORE;
                    end
                end
            end
            sfrp_pkg::SFRP_ST_ADDR: begin
                if (addr_last) begin
                    next_cnt = 5'h00;
                    if (dummy_clks == sfrp_pkg::DUMMY_CLKS_NONE) begin
                        next_state = sfrp_pkg::SFRP_ST_DATA;
                    end else begin
                        next_state = sfrp_pkg::SFRP_ST_DUMMY;
                    end
                end
            end
            sfrp_pkg::SFRP_ST_DUMMY: begin
                if (dummy_last) begin
                    next_cnt = 5'h00;
                    next_state = sfrp_pkg::SFRP_ST_DATA;
                end
            end
            sfrp_pkg::SFRP_ST_DATA: begin
                next_cnt = cnt;
                next_pos = byte_last ? 3'h0 : bit_pos + 3'h1;
            end
            sfrp_pkg::SFRP_ST_IGNORE: begin
                next_cnt = cnt;
            end
            default: begin
                next_cnt = cnt;
                next_state = sfrp_pkg::SFRP_ST_IGNORE;
            end
        endcase
    end

    // frame state, cleared whenever chip select is high or system reset
    always_ff @(posedge sck or posedge cs_n or posedge sys_rst) begin
        if (cs_n || sys_rst) begin
            state <= sfrp_pkg::SFRP_ST_CMD;
            kind <= sfrp_pkg::SFRP_KIND_NORMAL;
            cnt <= 5'h00;
            bit_pos <= 3'h0;
            op_sr <= 8'h00;
            addr_sr <= 24'h000000;
            mode_hi <= 2'h0;
        end else if (run) begin
            state <= next_state;
            kind <= next_kind;
            cnt <= next_cnt;
            bit_pos <= next_pos;
            op_sr <= next_op;
            addr_sr <= in_addr ? next_addr_sr : addr_sr;
            mode_hi <= mode_take ? io_in[1:0] : mode_hi;
        end
    end

    // state kept across frames
    always_ff @(posedge sck or posedge sys_rst) begin
        if (sys_rst) begin
            mem_addr <= '0;
            cont_mode <= 1'b0;
            rej_tgl <= 1'b0;
        end else if (run) begin
            if (addr_last) begin
                mem_addr <= next_addr_sr[ADDR_BITS-1:0];
            end else if (byte_last) begin
                mem_addr <= mem_addr + {{(ADDR_BITS-1){1'b0}}, 1'b1};
            end
            if (mode_done) begin
                cont_mode <= mode_keep;
            end
            if (reject) begin
                rej_tgl <= !rej_tgl;
            end
        end
    end

    // output chunk selection
    wire [2:0] shamt = (kind == sfrp_pkg::SFRP_KIND_QUAD) ? {bit_pos[0], 2'b00}
                     : (kind == sfrp_pkg::SFRP_KIND_DUAL) ? {bit_pos[1:0], 1'b0}
                     : bit_pos;
    wire [7:0] data_sh = mem_rdata << shamt;
    wire [3:0] chunk = (kind == sfrp_pkg::SFRP_KIND_QUAD) ? data_sh[7:4]
                     : (kind == sfrp_pkg::SFRP_KIND_DUAL) ? {2'b00, data_sh[7:6]}
                     : {2'b00, data_sh[7], 1'b0};
    wire [3:0] lane_oe_n = (kind == sfrp_pkg::SFRP_KIND_QUAD) ? sfrp_pkg::OE_N_QUAD
                         : (kind == sfrp_pkg::SFRP_KIND_DUAL) ? sfrp_pkg::OE_N_DUAL
                         : sfrp_pkg::OE_N_SINGLE;
    wire drive = (state == sfrp_pkg::SFRP_ST_DATA) && run;

    // falling-edge output stage
    always_ff @(negedge sck or posedge cs_n or posedge sys_rst) begin
        if (cs_n || sys_rst) begin
            io_out <= 4'h0;
            io_oe_n <= sfrp_pkg::OE_N_IDLE;
        end else begin
            io_out <= chunk;
            io_oe_n <= drive ? lane_oe_n : sfrp_pkg::OE_N_IDLE;
        end
    end

endmodule // sfrp_read_path

// ==== tb/sfrp_read_path_chk.sv ====
// assertions on the flash read path ports
`timescale 1ns/100ps
module sfrp_read_path_chk #(
    parameter int ADDR_BITS = 23
) (
    // system side
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic work_in_progress_flag,
    input wire logic quad_enable_bit,
    input wire logic quad_command_mode,
    input wire logic dtr_mode,
    input wire logic [3:0] dual_dummy_cycles,
    input wire logic [3:0] quad_dummy_cycles,
    input wire logic continuous_read_mode,
    input wire logic read_rejected,
    input wire logic [ADDR_BITS-1:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    // link side
    input wire logic sck,
    input wire logic cs_n,
    input wire logic hold_n,
    input wire logic [3:0] io_in,
    input wire logic [3:0] io_out,
    input wire logic [3:0] io_oe_n
);
    a_deselect_float: assert property (@(posedge sys_clk) disable iff (!rstn)
        cs_n |-> io_oe_n == 4'hF) else $error("lines driven while deselected");
    a_enable_codes: assert property (@(posedge sys_clk) disable iff (!rstn)
        io_oe_n inside {4'hF, 4'hD, 4'hC, 4'h0}) else $error("illegal enable pattern");
    a_busy_quiet: assert property (@(negedge sck) disable iff (!rstn || cs_n)
        work_in_progress_flag |-> io_oe_n == 4'hF) else $error("read served while busy");
    a_reject_pulse: assert property (@(posedge sys_clk) disable iff (!rstn)
        read_rejected |=> !read_rejected) else $error("reject flag longer than a cycle");
    a_rise_stable: assert property (@(posedge sys_clk) disable iff (!rstn)
        (sck && $past(sck) && !cs_n) |-> $stable(io_out) && $stable(io_oe_n))
        else $error("output moved while link clock high");
    a_held_float: assert property (@(negedge sck) disable iff (!rstn || cs_n)
        (!hold_n && !quad_enable_bit && !dtr_mode) ##1 !hold_n |-> io_oe_n == 4'hF)
        else $error("lines driven while held");
    a_quad_lanes: assert property (@(posedge sck) disable iff (!rstn || cs_n)
        io_oe_n == 4'h0 |-> quad_command_mode) else $error("four lanes outside quad mode");
    a_addr_step: assert property (@(posedge sck) disable iff (!rstn || cs_n)
        (io_oe_n != 4'hF && $past(io_oe_n) != 4'hF && $changed(mem_addr))
        |-> mem_addr == $past(mem_addr) + 1'b1)
        else $error("address did not step by one");
endmodule // sfrp_read_path_chk

// ==== tb/sfrp_host.sv ====
// spi host model driving the flash read path link
`timescale 1ns/100ps
module sfrp_host (
    // link toward the device
    output logic sck,
    output logic cs_n,
    output logic hold_n,
    output logic [3:0] io_in,
    // device drive
    input wire logic [3:0] io_out,
    input wire logic [3:0] io_oe_n
);
    logic [3:0] drv_v = 4'h0;
    logic [3:0] drv_en = 4'h0;
    logic [3:0] flt = 4'h5;
    // released lines toggle every clock
    assign io_in = (drv_en & drv_v) | (~drv_en & ~io_oe_n & io_out) | (~drv_en & io_oe_n & flt);
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        hold_n = 1'b1;
    end
    task automatic cyc(input logic [3:0] v, input logic [3:0] en, output logic [3:0] seen);
        drv_v = v;
        drv_en = en;
        #16 sck = 1'b1;
        seen = io_in;
        #16 sck = 1'b0;
        flt = ~flt;
    endtask
    task automatic start();
        while ($time % 8 != 3) #1;
        cs_n = 1'b0;
        #16;
    endtask
    task automatic stop();
        drv_en = 4'h0;
        #16 cs_n = 1'b1;
        #32;
    endtask
    task automatic send(input logic [31:0] v, input int n, input int w);
        logic [31:0] t;
        logic [3:0] m;
        logic [3:0] s;
        m = (w == 1) ? 4'h1 : (w == 2) ? 4'h3 : 4'hF;
        for (int i = 0; i < n; i++) begin
            t = v >> ((n - 1 - i) * w);
            cyc(t[3:0] & m, m, s);
        end
    endtask
    task automatic recv(input int w, output logic [7:0] b);
        logic [3:0] s;
        b = 8'h00;
        for (int i = 0; i < 8 / w; i++) begin
            cyc(4'h0, 4'h0, s);
            b = (w == 1) ? {b[6:0], s[1]} : (w == 2) ? {b[5:0], s[1:0]} : {b[3:0], s};
        end
    endtask
    task automatic pause(input int n);
        logic [3:0] s;
        #8 hold_n = 1'b0;
        repeat (n) cyc(4'hF, 4'h1, s);
        #8 hold_n = 1'b1;
    endtask
    task automatic hold_level(input logic v);
        hold_n = v;
    endtask
endmodule // sfrp_host

// ==== tb/serial_flash_read_path_test.sv ====
// self-checking bench for the serial flash read path
`timescale 1ns/100ps
module serial_flash_read_path_test;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [11:0] cfg_q = 12'h640;
    logic continuous_read_mode;
    logic read_rejected;
    logic [22:0] mem_addr;
    logic [7:0] mem_rdata;
    logic sck;
    logic cs_n;
    logic hold_n;
    logic [3:0] io_in;
    logic [3:0] io_out;
    logic [3:0] io_oe_n;
    int err_count = 0;
    int tests_run = 0;
    int rej_seen = 0;
    logic [7:0] ops [5] = '{8'h0B, 8'hEB, 8'h4B, 8'h5A, 8'h68};
    always #4 sys_clk = ~sys_clk;
    function automatic logic [7:0] mem_byte(input logic [22:0] a);
        return a[7:0] ^ a[15:8] ^ {1'b0, a[22:16]} ^ 8'h5A;
    endfunction
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    assign mem_rdata = mem_byte(mem_addr);
    always @(posedge sys_clk) if (read_rejected === 1'b1) rej_seen <= rej_seen + 1;
    sfrp_read_path u_dut (
        .sys_clk(sys_clk), .rstn(rstn), .work_in_progress_flag(cfg_q[0]),
        .quad_enable_bit(cfg_q[1]), .quad_command_mode(cfg_q[2]), .dtr_mode(cfg_q[3]),
        .dual_dummy_cycles(cfg_q[7:4]), .quad_dummy_cycles(cfg_q[11:8]),
        .continuous_read_mode(continuous_read_mode), .read_rejected(read_rejected),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata), .sck(sck), .cs_n(cs_n), .hold_n(hold_n),
        .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n)
    );
    sfrp_host u_host (
        .sck(sck), .cs_n(cs_n), .hold_n(hold_n), .io_in(io_in), .io_out(io_out),
        .io_oe_n(io_oe_n)
    );
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic cfg(input logic [11:0] v);
        @(posedge sys_clk);
        cfg_q <= v;
        u_host.start();
        u_host.send(32'h0, 8, 1);
        u_host.stop();
    endtask
    task automatic rd(input logic [7:0] op, input int ow, input logic [23:0] a, input int aw,
        input logic [7:0] md, input int nd, input int dw);
        logic [7:0] b;
        logic [3:0] s;
        u_host.start();
        if (ow > 0) u_host.send({24'h0, op}, 8 / ow, ow);
        u_host.send({8'h0, a}, 24 / aw, aw);
        if (aw == 2) u_host.send({28'h0, md[7:4]}, 2, 2);
        for (int i = (aw == 2) ? 2 : 0; i < nd; i++) u_host.cyc(4'h0, 4'h0, s);
        for (int k = 0; k < 2; k++) begin
            u_host.recv(dw, b);
            check("data", {24'h0, mem_byte(a[22:0] + 23'(k))}, {24'h0, b});
        end
        u_host.stop();
    endtask
    initial begin
        #400000;
        err_count++;
        $display("watchdog expired");
        report_and_stop();
    end
    initial begin
        logic [15:0] r;
        logic [7:0] b;
        int r0;
        r = 16'h0050;
        repeat (8) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        cfg(12'h640);
        for (int k = 0; k < 4; k++) begin
            r = lfsr_next(r);
            rd(sfrp_pkg::OP_NORMAL_READ, 1, {r, r[15:8]}, 1, 8'h00, 0, 1);
        end
        rd(sfrp_pkg::OP_NORMAL_READ, 1, 24'hFFFFFF, 1, 8'h00, 0, 1);
        rd(sfrp_pkg::OP_FAST_READ, 1, 24'h7FFFFF, 1, 8'h00, 8, 1);
        r = lfsr_next(r);
        u_host.start();
        u_host.send(32'h03, 8, 1);
        u_host.send({20'h0, r[11:0]}, 12, 1);
        u_host.pause(3);
        u_host.send({20'h0, r[11:0]}, 12, 1);
        u_host.recv(1, b);
        check("held read", {24'h0, mem_byte({r[10:0], r[11:0]})}, {24'h0, b});
        u_host.pause(2);
        u_host.stop();
        rd(sfrp_pkg::OP_DUAL_IO_READ, 1, {r, 8'h3C}, 2, 8'hA5, 4, 2);
        check("continuous", 32'h1, {31'h0, continuous_read_mode});
        rd(8'h00, 0, {8'h12, r}, 2, 8'h5F, 4, 2);
        check("continuous", 32'h0, {31'h0, continuous_read_mode});
        rd(sfrp_pkg::OP_FAST_READ, 1, {r, 8'hC3}, 1, 8'h00, 8, 1);
        cfg(12'h644);
        for (int k = 0; k < 5; k++) begin
            r = lfsr_next(r);
            rd(ops[k], 4, {r, 8'h00}, 4, 8'h00, 6, 4);
        end
        cfg(12'h144);
        rd(sfrp_pkg::OP_FAST_READ, 4, 24'h7FFFFF, 4, 8'h00, 1, 4);
        cfg(12'h642);
        u_host.hold_level(1'b0);
        rd(sfrp_pkg::OP_NORMAL_READ, 1, {r, 8'h55}, 1, 8'h00, 0, 1);
        u_host.hold_level(1'b1);
        cfg(12'h641);
        r0 = rej_seen;
        u_host.start();
        u_host.send(32'h03, 8, 1);
        u_host.send({8'h0, r, 8'h00}, 24, 1);
        u_host.recv(1, b);
        u_host.stop();
        repeat (8) @(posedge sys_clk);
        check("rejections", r0 + 1, rej_seen);
        report_and_stop();
    end
endmodule // serial_flash_read_path_test
bind sfrp_read_path sfrp_read_path_chk #(.ADDR_BITS(ADDR_BITS)) u_chk (
    .sys_clk(sys_clk), .rstn(rstn), .work_in_progress_flag(work_in_progress_flag),
    .quad_enable_bit(quad_enable_bit), .quad_command_mode(quad_command_mode),
    .dtr_mode(dtr_mode), .dual_dummy_cycles(dual_dummy_cycles),
    .quad_dummy_cycles(quad_dummy_cycles), .continuous_read_mode(continuous_read_mode),
    .read_rejected(read_rejected), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .sck(sck),
    .cs_n(cs_n), .hold_n(hold_n), .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n)
);
